/* inc/acos_cfg.svh */
// constants for the analog channel offset and slew block
`ifndef ACOS_CFG_SVH
`define ACOS_CFG_SVH
`define ACOS_CLK_MHZ 200
`define ACOS_LOOP_MS 10
`define ACOS_LOOP_CYC (`ACOS_LOOP_MS * `ACOS_CLK_MHZ * 1000)
`define ACOS_N_IN 8
`define ACOS_N_OUT 4
`define ACOS_SLEW_MAX 12'h800
`define ACOS_SLEW_MIN 12'h001
`define ACOS_RST_OFS 12'h000
`define ACOS_RST_OUT 12'h000
`define ACOS_SMAX 12'h7FF
`define ACOS_SMIN 12'h800
// byte addresses: channel index in bits 4:2, bank in bits 7:5
`define ACOS_BANK_IN_VAL 3'h0
`define ACOS_BANK_IN_OFS 3'h1
`define ACOS_BANK_IN_SLW 3'h2
`define ACOS_BANK_OUT_REQ 3'h3
`define ACOS_BANK_OUT_OFS 3'h4
`define ACOS_BANK_OUT_SLW 3'h5
`define ACOS_BANK_OUT_VAL 3'h6
`define ACOS_BANK_STAT 3'h7
`define ACOS_CHAN_LSB 2
`define ACOS_BANK_LSB 5
`endif

/* inc/acos_pkg.sv */
// types for the analog channel offset and slew block
package acos_pkg;
    typedef logic [11:0] acos_word_t;
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } acos_req_s;
    typedef enum logic [1:0] {
        ACOS_IDLE = 2'b00,
        ACOS_IN = 2'b01,
        ACOS_OUT = 2'b10
    } acos_state_e;
endpackage

/* core/acos_core.sv */
// analog channel offset add and slew limit with avalon register access
// Functional notes
// - all input reads and output updates happen once per 10 ms loop.
// - eight single-ended inputs are served; pairs may act as four balanced inputs; the core has no pairing, the host combines two reads.
// - four outputs each have their own value, offset and slew setting.
// - each input sample gets its channel offset added before further processing.
// - the change of each processed value per loop never exceeds its slew rate.
// - each input result reads as a 12-bit value sign-extended to 32 bits.
// - each output adds its offset to the host value and is slew limited before the converter.
// - all offsets clear to zero at start-up.
// - all slew rates start at their maximum of 2048 counts per loop.
// - all outputs start at the zero-volt code.
// - slew settings from 1 to 2048 counts per loop are accepted.
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "acos_cfg.svh"
module acos_core #(
    parameter int LOOP_CYC = `ACOS_LOOP_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic [95:0] I_ADC_DATA,
    output logic O_ADC_SAMPLE,
    output logic [47:0] O_DAC_DATA,
    output logic O_DAC_LOAD
);
    // a loop shorter than the pulse spacing would merge ticks
    if (LOOP_CYC < 4) begin : g_bad_loop
        $error("LOOP_CYC too small");
    end

    localparam int CW = 32;
    acos_pkg::acos_req_s req;
    assign req = '{I_AVS_ADDRESS, I_AVS_READ, I_AVS_WRITE, I_AVS_WRITEDATA};

    acos_pkg::acos_word_t in_val_r [`ACOS_N_IN];
    acos_pkg::acos_word_t in_ofs_r [`ACOS_N_IN];
    acos_pkg::acos_word_t in_slw_r [`ACOS_N_IN];
    acos_pkg::acos_word_t out_req_r [`ACOS_N_OUT];
    acos_pkg::acos_word_t out_ofs_r [`ACOS_N_OUT];
    acos_pkg::acos_word_t out_slw_r [`ACOS_N_OUT];
    acos_pkg::acos_word_t out_val_r [`ACOS_N_OUT];
    logic [CW-1:0] tick_cnt_r;
    logic tick_r;
    logic [15:0] loop_cnt_r;
    logic [31:0] rdata_r;
    logic wait_r;
    logic adc_sample_r;
    logic dac_load_r;
    logic [47:0] dac_data_r;
    acos_pkg::acos_word_t out_val_nxt [`ACOS_N_OUT];
    logic [31:0] rdata_nxt;

    // saturating signed 12-bit add
    function automatic acos_pkg::acos_word_t sat_add(input acos_pkg::acos_word_t a, input acos_pkg::acos_word_t b);
        logic signed [12:0] s;
        s = 13'($signed(a)) + 13'($signed(b));
        if (s > 13'sh07FF) begin
            sat_add = `ACOS_SMAX;
        end else if (s < -13'sh0800) begin
            sat_add = `ACOS_SMIN;
        end else begin
            sat_add = s[11:0];
        end
    endfunction

    // step cur toward tgt by at most rate; rate 0 stands for 2048
    function automatic acos_pkg::acos_word_t slew(input acos_pkg::acos_word_t cur, input acos_pkg::acos_word_t tgt,
                                                  input acos_pkg::acos_word_t rate);
        logic signed [13:0] d;
        logic signed [13:0] r;
        d = 14'($signed(tgt)) - 14'($signed(cur));
        r = (rate == 12'h000) ? 14'sh0800 : $signed({2'b00, rate});
        if (d > r) begin
            slew = 12'(14'($signed(cur)) + r);
        end else if (d < -r) begin
            slew = 12'(14'($signed(cur)) - r);
        end else begin
            slew = tgt;
        end
    endfunction

    // loop tick divider
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (tick_cnt_r == CW'(LOOP_CYC - 1)) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            loop_cnt_r <= 16'h0000;
        end else if (tick_r) begin
            loop_cnt_r <= loop_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            adc_sample_r <= 1'b0;
            dac_load_r <= 1'b0;
        end else begin
            adc_sample_r <= tick_r;
            dac_load_r <= tick_r;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            for (int i = 0; i < `ACOS_N_IN; i++) begin
                in_val_r[i] <= 12'h000;
            end
        end else if (tick_r) begin
            for (int i = 0; i < `ACOS_N_IN; i++) begin
                in_val_r[i] <= slew(in_val_r[i], sat_add(I_ADC_DATA[i*12 +: 12], in_ofs_r[i]), in_slw_r[i]);
            end
        end
    end

    // next output codes, shared by the value registers and the converter word
    always_comb begin
        for (int i = 0; i < `ACOS_N_OUT; i++) begin
            out_val_nxt[i] = slew(out_val_r[i], sat_add(out_req_r[i], out_ofs_r[i]), out_slw_r[i]);
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            for (int i = 0; i < `ACOS_N_OUT; i++) begin
                out_val_r[i] <= `ACOS_RST_OUT;
            end
        end else if (tick_r) begin
            for (int i = 0; i < `ACOS_N_OUT; i++) begin
                out_val_r[i] <= out_val_nxt[i];
            end
        end
    end

    // converter word takes the new codes at the loop step, so they stand while the load strobe is high
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            dac_data_r <= {4{`ACOS_RST_OUT}};
        end else if (tick_r) begin
            for (int i = 0; i < `ACOS_N_OUT; i++) begin
                dac_data_r[i*12 +: 12] <= out_val_nxt[i];
            end
        end
    end

    // register writes; slew rate 2048 is stored as 0 in 12 bits
    logic wr_go;
    logic [2:0] bank;
    logic [2:0] chan;
    // a write lands on the completing edge only, so a held request is taken once
    assign wr_go = req.write && !wait_r;
    assign bank = req.address[`ACOS_BANK_LSB +: 3];
    assign chan = req.address[`ACOS_CHAN_LSB +: 3];

    function automatic acos_pkg::acos_word_t slw_enc(input logic [31:0] v);
        if (v == 32'h0) begin
            slw_enc = `ACOS_SLEW_MIN;
        end else if (v >= 32'h800) begin
            slw_enc = 12'h000;
        end else begin
            slw_enc = v[11:0];
        end
    endfunction

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            for (int i = 0; i < `ACOS_N_IN; i++) begin
                in_ofs_r[i] <= `ACOS_RST_OFS;
                in_slw_r[i] <= 12'(`ACOS_SLEW_MAX);
            end
            for (int i = 0; i < `ACOS_N_OUT; i++) begin
                out_ofs_r[i] <= `ACOS_RST_OFS;
                out_slw_r[i] <= 12'(`ACOS_SLEW_MAX);
                out_req_r[i] <= `ACOS_RST_OUT;
            end
        end else if (wr_go) begin
            case (bank)
                `ACOS_BANK_IN_OFS: begin
                    in_ofs_r[chan] <= req.writedata[11:0];
                end
                `ACOS_BANK_IN_SLW: begin
                    in_slw_r[chan] <= slw_enc(req.writedata);
                end
                `ACOS_BANK_OUT_REQ: begin
                    if (!chan[2]) out_req_r[chan[1:0]] <= req.writedata[11:0];
                end
                `ACOS_BANK_OUT_OFS: begin
                    if (!chan[2]) out_ofs_r[chan[1:0]] <= req.writedata[11:0];
                end
                `ACOS_BANK_OUT_SLW: begin
                    if (!chan[2]) out_slw_r[chan[1:0]] <= slw_enc(req.writedata);
                end
                default: begin
                end
            endcase
        end
    end

    function automatic logic [31:0] slw_dec(input acos_pkg::acos_word_t s);
        slw_dec = (s == 12'h000) ? 32'h0000_0800 : {20'h00000, s};
    endfunction

    function automatic logic [31:0] sx(input acos_pkg::acos_word_t v);
        sx = {{20{v[11]}}, v};
    endfunction

    // one wait cycle: answer on the second edge of each request
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            wait_r <= 1'b1;
        end else if ((req.read || req.write) && wait_r) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end

    // read mux; unmapped banks and output channels 4..7 read as zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (bank)
            `ACOS_BANK_IN_VAL: begin
                rdata_nxt = sx(in_val_r[chan]);
            end
            `ACOS_BANK_IN_OFS: begin
                rdata_nxt = sx(in_ofs_r[chan]);
            end
            `ACOS_BANK_IN_SLW: begin
                rdata_nxt = slw_dec(in_slw_r[chan]);
            end
            `ACOS_BANK_OUT_REQ: begin
                if (!chan[2]) begin
                    rdata_nxt = sx(out_req_r[chan[1:0]]);
                end
            end
            `ACOS_BANK_OUT_OFS: begin
                if (!chan[2]) begin
                    rdata_nxt = sx(out_ofs_r[chan[1:0]]);
                end
            end
            `ACOS_BANK_OUT_SLW: begin
                if (!chan[2]) begin
                    rdata_nxt = slw_dec(out_slw_r[chan[1:0]]);
                end
            end
            `ACOS_BANK_OUT_VAL: begin
                if (!chan[2]) begin
                    rdata_nxt = sx(out_val_r[chan[1:0]]);
                end
            end
            `ACOS_BANK_STAT: begin
                if (chan == 3'h0) begin
                    rdata_nxt = {16'h0000, loop_cnt_r};
                end
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // read data is latched on the taking edge and stands through the answer cycle
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rdata_r <= 32'h0000_0000;
        end else if (req.read && wait_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign O_AVS_READDATA = rdata_r;
    assign O_AVS_WAITREQUEST = wait_r;
    assign O_ADC_SAMPLE = adc_sample_r;
    assign O_DAC_LOAD = dac_load_r;
    assign O_DAC_DATA = dac_data_r;
endmodule // acos_core

/* bench/acos_chk.sv */
// port assertions for the offset and slew block
`timescale 1ns/1ps
module acos_chk #(
    parameter int LOOP_CYC = 16
) (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic O_ADC_SAMPLE,
    input wire logic [47:0] O_DAC_DATA,
    input wire logic O_DAC_LOAD
);
    localparam int LGAP = LOOP_CYC;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    wire logic req = I_AVS_READ || I_AVS_WRITE;
    wire logic done = I_AVS_READ && !O_AVS_WAITREQUEST;
    wire logic [2:0] bank = I_AVS_ADDRESS[7:5];
    function automatic int d12(logic [11:0] a, logic [11:0] b);
        return int'($signed(a)) - int'($signed(b));
    endfunction
    sequence ans_s;
        !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
    endsequence
    one_wait_a: assert property (req && O_AVS_WAITREQUEST |=> ans_s) else $error("wait state wrong");
    idle_wait_a: assert property (!req && O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST) else $error("idle wait");
    loop_period_a: assert property (O_ADC_SAMPLE |-> ##LGAP O_ADC_SAMPLE) else $error("loop period");
    quiet_gap_a: assert property (O_ADC_SAMPLE |=> !O_ADC_SAMPLE [*8]) else $error("early tick");
    load_pair_a: assert property (O_ADC_SAMPLE == O_DAC_LOAD) else $error("load and sample apart");
    dac_hold_a: assert property (!O_DAC_LOAD |-> $stable(O_DAC_DATA)) else $error("dac moved");
    unmapped_zero_a: assert property (done && bank >= 3 && bank <= 6 && I_AVS_ADDRESS[4]
        |-> O_AVS_READDATA == 32'h0) else $error("unmapped read");
    sign_ext_a: assert property (done && bank == 3'h0
        |-> O_AVS_READDATA[31:12] == {20{O_AVS_READDATA[11]}}) else $error("no sign extension");
    for (genvar i = 0; i < 4; i++) begin : g_ch
        dac_slew_a: assert property (O_DAC_LOAD |-> d12(O_DAC_DATA[12*i+:12], $past(O_DAC_DATA[12*i+:12])) <= 2048
            && d12(O_DAC_DATA[12*i+:12], $past(O_DAC_DATA[12*i+:12])) >= -2048) else $error("dac step");
    end
endmodule // acos_chk
bind acos_core acos_chk #(.LOOP_CYC(LOOP_CYC)) u_chk (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_AVS_ADDRESS(I_AVS_ADDRESS),
    .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_ADC_SAMPLE(O_ADC_SAMPLE), .O_DAC_DATA(O_DAC_DATA),
    .O_DAC_LOAD(O_DAC_LOAD));

/* bench/acos_adc_model.sv */
// converter model: new samples on all inputs after every loop
`timescale 1ns/1ps
module acos_adc_model (
    input wire logic i_clk,
    input wire logic i_sample,
    output logic [95:0] o_data = 96'h0
);
    always @(posedge i_clk) begin
        if (i_sample === 1'b1) begin
            o_data <= {$urandom, $urandom, $urandom};
        end
    end
endmodule // acos_adc_model

/* bench/tb_top.sv */
// self-checking bench for the offset and slew block
`timescale 1ns/1ps
module tb_top;
    // short loop keeps the run small; accesses stay well inside one loop
    localparam int LOOP = 64;
    logic I_CLK = 1'b0;
    logic I_RSTN = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata, q, v;
    logic waitreq, smp, ld;
    logic [95:0] adc;
    logic [47:0] dac;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int c;
    int nloop = 0;
    int iv[8], io[8], is[8] = '{8{2048}}, oq[4], oo[4], os[4] = '{4{2048}}, ov[4];
    always #2.5 I_CLK = ~I_CLK;
    acos_core #(.LOOP_CYC(LOOP)) DUT (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
        .I_ADC_DATA(adc), .O_ADC_SAMPLE(smp), .O_DAC_DATA(dac), .O_DAC_LOAD(ld));
    acos_adc_model u_adc (.i_clk(I_CLK), .i_sample(smp), .o_data(adc));
    function automatic int sat(int x);
        return x > 2047 ? 2047 : (x < -2048 ? -2048 : x);
    endfunction
    function automatic int slew(int cur, int t, int r);
        return t > cur + r ? cur + r : (t < cur - r ? cur - r : t);
    endfunction
    function automatic int clr(logic [31:0] x);
        return x == 0 ? 1 : (x >= 2048 ? 2048 : int'(x));
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_dac();
        for (int i = 0; i < 4; i++) begin
            check("dac code", 32'(ov[i]), {{20{dac[12*i+11]}}, dac[12*i+:12]});
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [2:0] b, input logic [2:0] ch, input logic [31:0] d);
        addr <= {b, ch, 2'b00};
        rd <= ~w;
        wr <= w;
        wd <= d;
        do @(posedge I_CLK); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        addr <= ~addr;
        wd <= ~d;
        @(posedge I_CLK);
    endtask
    task automatic wait_pulse();
        do @(posedge I_CLK); while (smp !== 1'b1);
    endtask
    // model follows every loop update and checks the converter codes
    always @(posedge I_CLK) begin
        if (I_RSTN && smp === 1'b1) begin
            for (int i = 0; i < 8; i++) iv[i] = slew(iv[i], sat(int'($signed(adc[12*i+:12])) + io[i]), is[i]);
            for (int i = 0; i < 4; i++) ov[i] = slew(ov[i], sat(oq[i] + oo[i]), os[i]);
            check_dac();
            nloop++;
        end
    end
    always @(posedge I_CLK) begin
        cycles++;
        if (cycles > 12000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(51));
        repeat (10) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        for (int b = 1; b < 7; b++) begin
            wait_pulse();
            for (int ch = 0; ch < 8; ch++) begin
                bus(1'b0, 3'(b), 3'(ch), 32'h0);
                check("start reg", ((b == 2 || b == 5) && (b == 2 || ch < 4)) ? 32'h800 : 32'h0, q);
            end
        end
        wait_pulse();
        bus(1'b1, 3'h2, 3'h0, 32'h0);
        bus(1'b0, 3'h2, 3'h0, 32'h0);
        check("slew low", 32'h1, {20'h0, q[11:0]});
        bus(1'b1, 3'h5, 3'h3, 32'h0001_0000);
        bus(1'b0, 3'h5, 3'h3, 32'h0);
        check("slew high", 32'h800, {20'h0, q[11:0]});
        is[0] = 1;
        bus(1'b1, 3'h3, 3'h5, 32'h0000_0123);
        bus(1'b0, 3'h3, 3'h5, 32'h0);
        check("unmapped", 32'h0, q);
        repeat (40) begin
            wait_pulse();
            // balanced pairs are formed by the host from two of these reads
            for (int ch = 0; ch < 8; ch++) begin
                bus(1'b0, 3'h0, 3'(ch), 32'h0);
                check("input value", 32'(iv[ch]), q);
            end
            c = $urandom % 8;
            v = $urandom;
            bus(1'b1, 3'h1, 3'(c), v);
            io[c] = int'($signed(v[11:0]));
            v = $urandom % 4096;
            bus(1'b1, 3'h2, 3'(c), v);
            is[c] = clr(v);
            bus(1'b0, 3'h7, 3'h0, 32'h0);
            check("loop count", 32'(nloop), q);
            c = $urandom % 4;
            bus(1'b0, 3'h6, 3'(c), 32'h0);
            check("output value", 32'(ov[c]), q);
            v = $urandom;
            bus(1'b1, 3'h3, 3'(c), v);
            oq[c] = int'($signed(v[11:0]));
            v = $urandom;
            bus(1'b1, 3'h4, 3'(c), v);
            oo[c] = int'($signed(v[11:0]));
            v = $urandom % 4096;
            bus(1'b1, 3'h5, 3'(c), v);
            os[c] = clr(v);
        end
        end_of_test();
    end
endmodule // tb_top
